/* File: common/sdramp_pkg.sv */
// Package holding register map, field positions, reset values and mode codes for the step stage.
package sdramp_pkg;

	// Register addresses on the documented register port.
	localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION = 7'h00; // Global configuration.
	localparam logic [6:0] ADDR_STEP_WIDTH_DIR_SETUP = 7'h10; // Step width and direction setup.
	localparam logic [6:0] ADDR_RAMP_PROFILE_SELECT  = 7'h20; // Ramp profile select.
	localparam logic [6:0] ADDR_CURRENT_POSITION     = 7'h21; // Current position.
	localparam logic [6:0] ADDR_CURRENT_VELOCITY     = 7'h22; // Current velocity, read only.
	localparam logic [6:0] ADDR_VELOCITY_LIMIT       = 7'h24; // Velocity limit.
	localparam logic [6:0] ADDR_TARGET_POSITION      = 7'h37; // Target position.

	// Field positions inside the global configuration.
	localparam int GC_STEP_IDLE_POL_BIT = 3;  // Step output inverted.
	localparam int GC_STEP_TOGGLE_BIT   = 4;  // Step on each edge.
	localparam int GC_DIR_POL_BIT       = 5;  // Direction pin polarity.
	localparam int GC_REVERSE_DIR_BIT   = 28; // Travel direction invert.

	// Field positions inside the step width and direction setup register.
	localparam int SW_EXTRA_LSB = 0;  // Step extra length low bit.
	localparam int SW_SETUP_LSB = 16; // Direction setup delay low bit.

	// Values after reset.
	localparam logic [31:0] GLOBAL_CONFIGURATION_RST = 32'h0000_0020; // Direction high means negative.
	localparam logic [31:0] STEP_WIDTH_DIR_SETUP_RST = 32'h0000_0000; // Single-cycle steps.
	localparam logic [2:0]  RAMP_PROFILE_SELECT_RST  = 3'h0;          // Velocity mode, no ramp.
	localparam logic [31:0] VELOCITY_LIMIT_RST       = 32'h0000_0000; // Standstill.
	localparam logic [31:0] POSITION_RST             = 32'h0000_0000; // Origin.

	// Bit inside the profile select that picks positioning mode.
	localparam int RP_POSITIONING_BIT = 2; // Operation mode bit.

	// Velocity accumulator: limit has 8 fractional bits.
	localparam int VEL_FRAC_BITS = 8;  // Fraction bits of the velocity limit.
	localparam int ACC_BITS      = 40; // Phase accumulator width.

	// Motion profiles decoded from the low two select bits.
	typedef enum logic [1:0] {
		SDRAMP_PROF_NONE = 2'h0,
		SDRAMP_PROF_TRAP = 2'h1,
		SDRAMP_PROF_SCRV = 2'h2,
		SDRAMP_PROF_RSVD = 2'h3
	} sdramp_prof_e;

endpackage

/* File: common/sdramp_step_if.sv */
// Interface carrying step requests from the ramp side to the pulse stage.
`timescale 1ns/100ps
interface sdramp_step_if;
	logic        req;        // Step wanted this cycle.
	logic        dir_neg;    // Requested travel direction is negative.
	logic        ready;      // Pulse stage can take a step.
	logic        taken;      // Pulse stage took the step.
	logic [15:0] extra_len;  // Step extra length.
	logic [15:0] setup_dly;  // Direction setup delay.
	logic        idle_pol;   // Step output inverted.
	logic        toggle;     // Step on each edge.
	logic        dir_pol;    // Direction pin polarity.
	logic        step_out;   // Step pin level.
	logic        dir_out;    // Direction pin level.

	modport ramp  (output req, dir_neg, extra_len, setup_dly, idle_pol, toggle, dir_pol,
	               input ready, taken, step_out, dir_out);
	modport pulse (input req, dir_neg, extra_len, setup_dly, idle_pol, toggle, dir_pol,
	               output ready, taken, step_out, dir_out);
endinterface

/* File: core/sdramp_pulse.sv */
// Step pulse stage: pulse width, direction hold and setup, and pin encoding.
`timescale 1ns/100ps
module sdramp_pulse (
	input  wire logic  clk_i,   // System clock.
	input  wire logic  rst_b_i, // Synchronised active-low reset.
	sdramp_step_if.pulse s      // Step request channel.
);

	// Phases of one step.
	typedef enum logic [1:0] {SDRAMP_P_IDLE, SDRAMP_P_HIGH, SDRAMP_P_HOLD} sdramp_pst_e;

	sdramp_pst_e state_reg;      // Current phase.
	logic [16:0] cnt_reg;        // Down counter for high and hold phases.
	logic [15:0] setup_cnt_reg;  // Remaining direction setup cycles.
	logic        dir_neg_reg;    // Direction currently presented.
	logic        pulse_reg;      // Raw active pulse.
	logic        tog_reg;        // Toggle-mode level.
	logic        step_reg;       // Registered step pin.
	logic        dir_reg;        // Registered direction pin.

	// A step may start only when idle, setup done and direction already matches.
	assign s.ready = (state_reg == SDRAMP_P_IDLE) && (setup_cnt_reg == 16'h0000)
		&& (s.dir_neg == dir_neg_reg);
	assign s.taken = s.ready && s.req;
	assign s.step_out = step_reg;
	assign s.dir_out  = dir_reg;

	// Phase sequencing: high for extra+1 cycles, then hold extra+1 cycles.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= SDRAMP_P_IDLE;
			cnt_reg   <= 17'h00000;
			pulse_reg <= 1'b0;
			tog_reg   <= 1'b0;
		end else begin
			case (state_reg)
				SDRAMP_P_IDLE: begin
					if (s.taken) begin
						state_reg <= SDRAMP_P_HIGH;
						cnt_reg   <= {1'b0, s.extra_len};
						pulse_reg <= 1'b1;
						tog_reg   <= ~tog_reg;
					end
				end
				SDRAMP_P_HIGH: begin
					if (cnt_reg == 17'h00000) begin
						state_reg <= SDRAMP_P_HOLD;
						pulse_reg <= 1'b0;
						cnt_reg   <= {1'b0, s.extra_len};
					end else begin
						cnt_reg <= cnt_reg - 17'h00001;
					end
				end
				SDRAMP_P_HOLD: begin
					if (cnt_reg == 17'h00000) begin
						state_reg <= SDRAMP_P_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 17'h00001;
					end
				end
				default: state_reg <= SDRAMP_P_IDLE;
			endcase
		end
	end

	// Direction changes only when idle; each change restarts the setup delay.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dir_neg_reg   <= 1'b0;
			setup_cnt_reg <= 16'h0000;
		end else if (state_reg == SDRAMP_P_IDLE && s.req && s.dir_neg != dir_neg_reg) begin
			dir_neg_reg   <= s.dir_neg;
			setup_cnt_reg <= s.setup_dly;
		end else if (setup_cnt_reg != 16'h0000) begin
			setup_cnt_reg <= setup_cnt_reg - 16'h0001;
		end
	end

	// Pin encoding from the raw pulse and direction.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			step_reg <= 1'b0;
			dir_reg  <= 1'b0;
		end else begin
			if (s.toggle) begin
				step_reg <= tog_reg;
			end else begin
				step_reg <= pulse_reg ^ s.idle_pol;
			end
			// Polarity bit set: high means negative; cleared: high means positive.
			dir_reg <= s.dir_pol ? dir_neg_reg : ~dir_neg_reg;
		end
	end

endmodule

/* File: core/sdramp_top.sv */
// Step/direction output stage with operating-mode and profile selection of the ramp generator.
`timescale 1ns/100ps
module sdramp_top #(
	parameter int MSTEP_BITS = 10 // Microstep counter width.
) (
	input  wire logic        clk_i,         // System clock, 100 MHz.
	input  wire logic        rst_b_i,       // Asynchronous active-low reset.
	input  wire logic        reg_wr_i,      // Register write strobe.
	input  wire logic        reg_rd_i,      // Register read strobe.
	input  wire logic [6:0]  reg_addr_i,    // Register address.
	input  wire logic [31:0] reg_wdata_i,   // Register write data.
	output logic      [31:0] reg_rdata_o,   // Registered read data.
	output logic             step_output_o,      // Step pin.
	output logic             direction_output_o, // Direction pin.
	output logic [MSTEP_BITS-1:0] microstep_counter_o, // Microstep counter.
	output logic             positioning_o, // High in positioning mode.
	output logic [1:0]       profile_o      // Selected motion profile.
);

	initial begin
		if (MSTEP_BITS < 2 || MSTEP_BITS > 16) begin
			$error("MSTEP_BITS must lie between 2 and 16");
		end
	end

	// Reset release through two flip-flops.
	logic rst_meta_reg; // First reset stage.
	logic rst_sync_reg; // Reset used by the design.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Host-written registers, and the read-only current velocity.
	logic [31:0] global_configuration_reg;            // Global configuration.
	logic [31:0] step_width_and_direction_setup_reg;  // Extra length and setup delay.
	logic [2:0]  ramp_profile_select_reg;             // Mode and profile.
	logic [31:0] velocity_limit_reg;                  // Signed, 8 fraction bits.
	logic [31:0] target_position_reg;                 // Target position.
	logic [31:0] current_position_reg;                // Current position in steps.
	logic [23:0] current_velocity_reg;                // Current velocity, integer part.

	// Register writes; the position may also be set by the host.
	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			global_configuration_reg           <= sdramp_pkg::GLOBAL_CONFIGURATION_RST;
			step_width_and_direction_setup_reg <= sdramp_pkg::STEP_WIDTH_DIR_SETUP_RST;
			ramp_profile_select_reg            <= sdramp_pkg::RAMP_PROFILE_SELECT_RST;
			velocity_limit_reg                 <= sdramp_pkg::VELOCITY_LIMIT_RST;
			target_position_reg                <= sdramp_pkg::POSITION_RST;
		end else if (reg_wr_i) begin
			if (reg_addr_i == sdramp_pkg::ADDR_GLOBAL_CONFIGURATION) begin
				global_configuration_reg <= reg_wdata_i;
			end else if (reg_addr_i == sdramp_pkg::ADDR_STEP_WIDTH_DIR_SETUP) begin
				step_width_and_direction_setup_reg <= reg_wdata_i;
			end else if (reg_addr_i == sdramp_pkg::ADDR_RAMP_PROFILE_SELECT) begin
				ramp_profile_select_reg <= reg_wdata_i[2:0];
			end else if (reg_addr_i == sdramp_pkg::ADDR_VELOCITY_LIMIT) begin
				velocity_limit_reg <= reg_wdata_i;
			end else if (reg_addr_i == sdramp_pkg::ADDR_TARGET_POSITION) begin
				target_position_reg <= reg_wdata_i;
			end
		end
	end

	// Read data, registered; unmapped addresses read zero.
	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			if (reg_addr_i == sdramp_pkg::ADDR_GLOBAL_CONFIGURATION) begin
				reg_rdata_o <= global_configuration_reg;
			end else if (reg_addr_i == sdramp_pkg::ADDR_STEP_WIDTH_DIR_SETUP) begin
				reg_rdata_o <= step_width_and_direction_setup_reg;
			end else if (reg_addr_i == sdramp_pkg::ADDR_RAMP_PROFILE_SELECT) begin
				reg_rdata_o <= {29'h0000_0000, ramp_profile_select_reg};
			end else if (reg_addr_i == sdramp_pkg::ADDR_CURRENT_POSITION) begin
				reg_rdata_o <= current_position_reg;
			end else if (reg_addr_i == sdramp_pkg::ADDR_CURRENT_VELOCITY) begin
				reg_rdata_o <= {{8{current_velocity_reg[23]}}, current_velocity_reg};
			end else if (reg_addr_i == sdramp_pkg::ADDR_VELOCITY_LIMIT) begin
				reg_rdata_o <= velocity_limit_reg;
			end else if (reg_addr_i == sdramp_pkg::ADDR_TARGET_POSITION) begin
				reg_rdata_o <= target_position_reg;
			end else begin
				reg_rdata_o <= 32'h0000_0000;
			end
		end
	end

	// Mode and profile decoding.
	logic                   pos_mode;  // Positioning mode selected.
	sdramp_pkg::sdramp_prof_e profile; // Selected profile.
	assign pos_mode = ramp_profile_select_reg[sdramp_pkg::RP_POSITIONING_BIT];
	assign profile  = sdramp_pkg::sdramp_prof_e'(ramp_profile_select_reg[1:0]);
	assign positioning_o = pos_mode;
	assign profile_o     = ramp_profile_select_reg[1:0];

	// Magnitude of the velocity limit; sign is dropped in positioning mode.
	logic [31:0] vlim_mag;  // Absolute velocity limit.
	logic        vlim_neg;  // Velocity limit sign.
	assign vlim_neg = velocity_limit_reg[31];
	assign vlim_mag = vlim_neg ? (32'h0000_0000 - velocity_limit_reg) : velocity_limit_reg;

	// Travel request: velocity mode follows the limit sign, positioning mode the target.
	logic move_en;   // Motion wanted.
	logic move_neg;  // Wanted direction is negative.
	always_comb begin
		if (pos_mode) begin
			move_en  = (current_position_reg != target_position_reg) && (vlim_mag != 32'h0);
			move_neg = $signed(target_position_reg) < $signed(current_position_reg);
		end else begin
			move_en  = (vlim_mag != 32'h0);
			move_neg = vlim_neg;
		end
	end

	// The ramp arithmetic is not implemented here: every profile follows the limit
	// directly, which is the no-ramp behaviour; other codes are held for the ramp core.
	logic [sdramp_pkg::ACC_BITS-1:0] acc_reg; // Step phase accumulator.
	logic                            step_due; // Accumulator overflow wants a step.
	logic [sdramp_pkg::ACC_BITS:0]   acc_sum;  // Accumulator plus increment.
	assign acc_sum  = {1'b0, acc_reg} + {9'h000, vlim_mag};
	assign step_due = acc_sum[sdramp_pkg::ACC_BITS];

	sdramp_step_if sif ();

	// Pending step waits until the pulse stage is ready.
	logic pend_reg; // Step pending.
	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			acc_reg  <= '0;
			pend_reg <= 1'b0;
		end else begin
			if (move_en && !pend_reg) begin
				acc_reg <= acc_sum[sdramp_pkg::ACC_BITS-1:0];
			end
			if (sif.taken) begin
				pend_reg <= 1'b0;
			end else if (move_en && step_due) begin
				pend_reg <= 1'b1;
			end
			if (!move_en) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// Internal velocity shown as integer steps; zero when idle.
	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			current_velocity_reg <= 24'h000000;
		end else if (!move_en) begin
			current_velocity_reg <= 24'h000000;
		end else begin
			current_velocity_reg <= move_neg ? (24'h000000 - vlim_mag[31:8]) : vlim_mag[31:8];
		end
	end

	// Microstep travel direction, optionally reversed.
	logic mstep_back; // Microstep counter runs backward.
	assign mstep_back = move_neg ^ global_configuration_reg[sdramp_pkg::GC_REVERSE_DIR_BIT];

	// Position and microstep counter advance with each accepted step, except in a cycle with a host position write.
	logic [MSTEP_BITS-1:0] mstep_reg; // Microstep counter.
	always_ff @(posedge clk_i or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			current_position_reg <= sdramp_pkg::POSITION_RST;
			mstep_reg            <= '0;
		end else if (reg_wr_i && reg_addr_i == sdramp_pkg::ADDR_CURRENT_POSITION) begin
			current_position_reg <= reg_wdata_i;
		end else if (sif.taken) begin
			current_position_reg <= move_neg ? current_position_reg - 32'h1
				: current_position_reg + 32'h1;
			mstep_reg <= mstep_back ? mstep_reg - 1'b1 : mstep_reg + 1'b1;
		end
	end
	assign microstep_counter_o = mstep_reg;

	// Channel to the pulse stage; direction comes from microstep travel.
	assign sif.req       = pend_reg && move_en;
	assign sif.dir_neg   = mstep_back;
	assign sif.extra_len = step_width_and_direction_setup_reg[sdramp_pkg::SW_EXTRA_LSB +: 16];
	assign sif.setup_dly = step_width_and_direction_setup_reg[sdramp_pkg::SW_SETUP_LSB +: 16];
	assign sif.idle_pol  = global_configuration_reg[sdramp_pkg::GC_STEP_IDLE_POL_BIT];
	assign sif.toggle    = global_configuration_reg[sdramp_pkg::GC_STEP_TOGGLE_BIT];
	assign sif.dir_pol   = global_configuration_reg[sdramp_pkg::GC_DIR_POL_BIT];

	sdramp_pulse u_pulse (
		.clk_i   (clk_i),
		.rst_b_i (rst_sync_reg),
		.s       (sif)
	);

	assign step_output_o      = sif.step_out;
	assign direction_output_o = sif.dir_out;

endmodule

/* File: testbench/sdramp_drv_model.sv */
// Stepper driver stand-in that counts step pin edges.
`timescale 1ns/100ps
module sdramp_drv_model (
	input  wire logic        clk_i,  // Clock.
	input  wire logic        clr_i,  // Clear the counts.
	input  wire logic        step_i, // Step pin.
	output logic      [15:0] rise_o, // Rising edges seen.
	output logic      [15:0] fall_o  // Falling edges seen.
);
	logic last; // Step level one cycle ago.
	// Edges are sampled on the system clock, like a filtered driver input.
	always_ff @(posedge clk_i) begin
		last <= step_i;
		if (clr_i) begin
			rise_o <= 16'h0;
			fall_o <= 16'h0;
		end else begin
			if (step_i && !last) rise_o <= rise_o + 16'h1;
			if (!step_i && last) fall_o <= fall_o + 16'h1;
		end
	end
endmodule

/* File: testbench/sdramp_top_asserts.sv */
// Checker for the step stage top ports.
`timescale 1ns/100ps
module sdramp_top_asserts #(
	parameter int MSTEP_BITS = 10 // Microstep counter width.
) (
	input wire logic                  clk_i,               // Clock.
	input wire logic                  rst_b_i,             // Reset, low.
	input wire logic                  reg_wr_i,            // Write strobe.
	input wire logic [6:0]            reg_addr_i,          // Address.
	input wire logic [31:0]           reg_wdata_i,         // Write data.
	input wire logic                  step_output_o,       // Step pin.
	input wire logic                  direction_output_o,  // Direction pin.
	input wire logic [MSTEP_BITS-1:0] microstep_counter_o, // Microstep counter.
	input wire logic                  positioning_o,       // Mode bit.
	input wire logic [1:0]            profile_o            // Profile.
);
	logic [31:0] cfg, vel;          // Shadow configuration and velocity limit.
	logic [15:0] ext, stp;          // Shadow extra length and setup delay.
	logic [7:0]  still, age;        // Cycles since any write, since a timing write.
	logic [16:0] hi, lo, dc;        // Active, inactive and same-direction run lengths.
	logic        dq, act, neg, ok;  // Helper bits.
	logic        wc, ws, wv, wm;    // Write decodes.
	assign wc = reg_wr_i && reg_addr_i == sdramp_pkg::ADDR_GLOBAL_CONFIGURATION;
	assign ws = reg_wr_i && reg_addr_i == sdramp_pkg::ADDR_STEP_WIDTH_DIR_SETUP;
	assign wv = reg_wr_i && reg_addr_i == sdramp_pkg::ADDR_VELOCITY_LIMIT;
	assign wm = reg_wr_i && reg_addr_i == sdramp_pkg::ADDR_RAMP_PROFILE_SELECT;
	assign act = step_output_o ^ cfg[3];
	assign neg = vel[31] ^ cfg[28];
	assign ok = age > 8'h28 && !cfg[4];
	// Shadow copies of the host registers.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg <= sdramp_pkg::GLOBAL_CONFIGURATION_RST;
			{stp, ext} <= sdramp_pkg::STEP_WIDTH_DIR_SETUP_RST;
			vel <= sdramp_pkg::VELOCITY_LIMIT_RST;
		end else begin
			if (wc) cfg <= reg_wdata_i;
			if (ws) {stp, ext} <= reg_wdata_i;
			if (wv) vel <= reg_wdata_i;
		end
	end
	// Run-length counters; all but hi saturate, so long waits never wrap them.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			still <= 8'h0;
			age <= 8'h0;
			hi <= 17'h0;
			lo <= 17'h1ffff;
			dc <= 17'h1ffff;
			dq <= 1'b0;
		end else begin
			still <= reg_wr_i ? 8'h0 : still + {7'h0, still != 8'hff};
			age <= (wc || ws) ? 8'h0 : age + {7'h0, age != 8'hff};
			hi <= act ? hi + 17'h1 : 17'h0;
			lo <= act ? 17'h0 : lo + {16'h0, lo != 17'h1ffff};
			dq <= direction_output_o;
			dc <= (direction_output_o != dq) ? 17'h0 : dc + {16'h0, dc != 17'h1ffff};
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_mode; wm |=> positioning_o == $past(reg_wdata_i[2]); endproperty
	a_mode: assert property (p_mode) else $error("mode bit wrong");
	property p_prof; wm |=> profile_o == $past(reg_wdata_i[1:0]); endproperty
	a_prof: assert property (p_prof) else $error("profile wrong");
	property p_width; ok && $fell(act) |-> hi == {1'b0, ext} + 17'h1; endproperty
	a_width: assert property (p_width) else $error("step width wrong");
	property p_freeze; ok && act |-> $stable(direction_output_o); endproperty
	a_freeze: assert property (p_freeze) else $error("direction moved in pulse");
	property p_hold; ok && $changed(direction_output_o) |-> lo >= {1'b0, ext} + 17'h1;
	endproperty
	a_hold: assert property (p_hold) else $error("direction moved too soon");
	property p_setup; ok && $rose(act) |-> dc + 17'h1 >= {1'b0, stp}; endproperty
	a_setup: assert property (p_setup) else $error("step inside setup delay");
	property p_idle; still == 8'h28 && vel == 32'h0 && !cfg[4] |-> step_output_o == cfg[3];
	endproperty
	a_idle: assert property (p_idle) else $error("step idle level wrong");
	property p_dir; ok && $rose(act) && vel != 32'h0 && !positioning_o && still > 8'h3
		|-> direction_output_o == (cfg[5] ~^ neg); endproperty
	a_dir: assert property (p_dir) else $error("direction level wrong");
	property p_ms; !positioning_o && vel != 32'h0 && still > 8'h3 && $changed(microstep_counter_o)
		|-> microstep_counter_o == $past(microstep_counter_o)
		+ (neg ? {MSTEP_BITS{1'b1}} : MSTEP_BITS'(1)); endproperty
	a_ms: assert property (p_ms) else $error("microstep moved wrong way");
endmodule

/* File: testbench/sdramp_top_tb_top.sv */
// Bench for the step stage: register access, motion runs and the verdict.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t: got %0h want %0h", $time, (a), (b)); end end
module sdramp_top_tb_top;
	localparam logic [6:0] CFG = sdramp_pkg::ADDR_GLOBAL_CONFIGURATION; // Short aliases.
	localparam logic [6:0] VEL = sdramp_pkg::ADDR_VELOCITY_LIMIT;
	localparam logic [6:0] SEL = sdramp_pkg::ADDR_RAMP_PROFILE_SELECT;
	localparam logic [6:0] POS = sdramp_pkg::ADDR_CURRENT_POSITION;
	localparam logic [6:0] TGT = sdramp_pkg::ADDR_TARGET_POSITION;
	logic        clk_i = 1'b0, rst_b_i = 1'b0, wr_s = 1'b0, rd_s = 1'b0, clr = 1'b1; // Stimulus.
	logic [6:0]  addr = 7'h00;          // Register address.
	logic [31:0] wdat = 32'h0, rdat;    // Register data.
	logic        stp, dir, pos;         // Pins and mode.
	logic [1:0]  prof;                  // Profile.
	logic [9:0]  ms, ms0;               // Microstep counter now and at run start.
	logic [15:0] rise, fall;            // Edge counts from the driver model.
	int          n_fail = 0, samples_checked = 0, cyc = 0; // Counters.
	logic [6:0]  ra [6] = '{7'h00, 7'h10, 7'h20, 7'h24, 7'h21, 7'h05}; // Reset table.
	logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};    // Profile codes.
	always #5 clk_i = ~clk_i; // 100 MHz clock.
	sdramp_top #(.MSTEP_BITS(10)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr_s),
		.reg_rd_i(rd_s), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat),
		.step_output_o(stp), .direction_output_o(dir), .microstep_counter_o(ms),
		.positioning_o(pos), .profile_o(prof));
	sdramp_drv_model drv (.clk_i(clk_i), .clr_i(clr), .step_i(stp), .rise_o(rise),
		.fall_o(fall));
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// One-cycle write strobe.
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_s <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk_i);
		wr_s <= 1'b0;
	endtask
	// Read, then compare once the registered data has landed.
	task automatic rdc(input logic [6:0] a, input logic [31:0] e);
		@(posedge clk_i);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd_s <= 1'b0;
		@(posedge clk_i);
		#1 `CHK(rdat, e)
	endtask
	task automatic clear;
		clr <= 1'b1;
		wt(2);
		clr <= 1'b0;
	endtask
	// Velocity run; k picks which edges mark a step: rises, falls or both.
	task automatic run(input logic [31:0] c, input logic [31:0] v, input int k);
		logic [15:0] n;
		wr(CFG, c);
		wt(60);
		clear();
		ms0 = ms;
		wr(VEL, v);
		wt(4000);
		rdc(sdramp_pkg::ADDR_CURRENT_VELOCITY, v[31] ? 32'hff80_0001 : 32'h007f_ffff);
		wr(VEL, 32'h0);
		wt(60);
		n = (k == 0) ? rise : (k == 1) ? fall : rise + fall;
		`CHK(n != 16'h0, 1'b1)
		`CHK(ms - ms0, (v[31] ^ c[28]) ? 10'h0 - n[9:0] : n[9:0])
		$display("run with configuration %0h done", c);
	endtask
	task automatic results;
		$display("checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// A hang counts as a mismatch.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 50000) begin
			n_fail++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		wt(3);
		foreach (ra[i]) rdc(ra[i], (i == 0) ? 32'h20 : 32'h0);
		wr(sdramp_pkg::ADDR_CURRENT_VELOCITY, 32'h1234);
		rdc(sdramp_pkg::ADDR_CURRENT_VELOCITY, 32'h0);
		$display("reset test done");
		run(32'h20, 32'h7fff_ff00, 0);
		wr(sdramp_pkg::ADDR_STEP_WIDTH_DIR_SETUP, 32'h0006_0002);
		run(32'h28, 32'h8000_0100, 1);
		run(32'h30, 32'h7fff_ff00, 2);
		run(32'h00, 32'h8000_0100, 0);
		run(32'h1000_0020, 32'h7fff_ff00, 0);
		wr(VEL, 32'h7fff_ff00);
		wt(1500);
		wr(VEL, 32'h8000_0100);
		wt(1500);
		wr(VEL, 32'h0);
		$display("reversal test done");
		wr(CFG, 32'h20);
		wr(POS, 32'h0);
		wr(TGT, 32'h6);
		wr(SEL, 32'h4);
		clear();
		wr(VEL, 32'h8000_0100);
		wt(5000);
		rdc(POS, 32'h6);
		`CHK(rise, 16'h6)
		wr(SEL, 32'h5);
		wr(TGT, 32'h2);
		wt(4000);
		rdc(POS, 32'h2);
		wr(VEL, 32'h0);
		$display("positioning test done");
		foreach (codes[i]) begin
			wr(SEL, {29'h0, codes[i]});
			rdc(SEL, {29'h0, codes[i]});
			`CHK({pos, prof}, codes[i])
		end
		$display("profile test done");
		results();
	end
endmodule
bind sdramp_top sdramp_top_asserts #(.MSTEP_BITS(MSTEP_BITS)) chk (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .step_output_o(step_output_o),
	.direction_output_o(direction_output_o), .microstep_counter_o(microstep_counter_o),
	.positioning_o(positioning_o), .profile_o(profile_o));
